// File: pkg/cco_pkg.sv
// Function
// - subroutine jump pushes program counter plus one onto the return stack top
// - subroutine jump loads 11-bit operand into bits 10:0, latch bits 4:3 into 12:11
// - subroutine jump takes two instruction cycles and leaves all status flags alone
// - watchdog restart clears the watchdog count and its prescaler
// - watchdog restart sets both active-low expired and sleep-entered flags to one
// - clear-register writes 00h into the addressed register and sets the zero flag
// - invert-register complements the addressed register, touching only the zero flag
// - invert-register writes accumulator when destination bit is 0, register when 1
// - clear-accumulator loads 00h into the accumulator and sets the zero flag
// - decrement-register subtracts one, destination by select bit, zero flag only
`default_nettype none

package cco_pkg;

  // widths
  localparam int PC_W      = 13;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 7;
  localparam int K_W       = 11;
  localparam int LATCH_W   = 5;
  localparam int BUS_AW    = 10;
  localparam int BUS_DW    = 32;

  // instruction timing: clocks per instruction cycle, then lengths in instruction cycles
  localparam int TCY_CLKS  = 4;
  localparam int CALL_TCY  = 2;
  localparam int BASIC_TCY = 1;

  // register byte addresses
  localparam logic [BUS_AW-1:0] ADDR_CMD    = 10'h000;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 10'h004;
  localparam logic [BUS_AW-1:0] ADDR_PC     = 10'h008;
  localparam logic [BUS_AW-1:0] ADDR_LATCH  = 10'h00C;
  localparam logic [BUS_AW-1:0] ADDR_ACC    = 10'h010;
  localparam logic [BUS_AW-1:0] ADDR_STACK  = 10'h014;
  // register file window: byte 0x200 + 4 * file address
  localparam int FILE_SEL_BIT = 9;

  // command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_DEST    = 3;
  localparam int CMD_ARG_LSB = 8;

  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_ZERO    = 1;
  localparam int ST_EXPIRED = 2;
  localparam int ST_SLEEP   = 3;

  // stack register fields
  localparam int STK_PTR_LSB = 16;

  // reset values
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [DATA_W-1:0]  ZERO_BYTE = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;

  // bus read sequencing
  localparam logic [1:0] RD_ISSUE   = 2'h0;
  localparam logic [1:0] RD_CAPTURE = 2'h1;
  localparam logic [1:0] RD_DONE    = 2'h2;

  typedef enum logic [2:0] {
    OP_NOP                   = 3'h0,
    OP_CALL                  = 3'h1,
    OP_WATCHDOG_RESTART      = 3'h2,
    OP_CLEAR_REGISTER        = 3'h3,
    OP_INVERT_REGISTER       = 3'h4,
    OP_CLEAR_ACCUMULATOR     = 3'h5,
    OP_DECREMENT_REGISTER    = 3'h6
  } cco_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_RUN
  } cco_state_e;

endpackage

`default_nettype wire

// File: rtl/cco_exec.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none

// executes one command written over the bus, paced by the instruction-cycle enable
module cco_exec
  import cco_pkg::*;
#(
  parameter int TCY_DIV     = TCY_CLKS,
  parameter int STACK_DEPTH = 8,
  parameter int FILE_DEPTH  = 128
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_DW-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [BUS_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // core events that clear the status flags
  input  wire logic              watchdog_timeout,
  input  wire logic              sleep_entry,
  // watchdog clear strobes
  output logic                   watchdog_count_clear,
  output logic                   watchdog_prescaler_clear
);

  localparam int TCW = $clog2(TCY_DIV + 1);
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam logic [TCW-1:0] TCY_LAST = TCW'(TCY_DIV - 1);
  localparam logic [1:0]     CYC_CALL = 2'(CALL_TCY);
  localparam logic [1:0]     CYC_BASE = 2'(BASIC_TCY);

  cco_state_e            state;
  logic [TCW-1:0]        tcy_cnt;
  logic                  tcy_tick;
  logic [1:0]            cyc_left;
  logic [1:0]            rd_stage;

  cco_op_e               cmd_op;
  logic                  cmd_dest;
  logic [K_W-1:0]        cmd_arg;

  logic [PC_W-1:0]       program_counter;
  logic [LATCH_W-1:0]    upper_program_latch;
  logic [DATA_W-1:0]     acc;
  logic                  zero_flag;
  logic                  watchdog_expired_flag_n;
  logic                  sleep_entered_flag_n;
  logic [PC_W-1:0]       stack_mem [STACK_DEPTH];
  logic [SPW-1:0]        stack_ptr;
  logic [PC_W-1:0]       stack_top;

  logic                  busy;
  logic                  sel_file;
  logic [FADDR_W-1:0]    bus_faddr;
  logic                  bus_wr;
  logic                  bus_rd_go;
  logic                  start;
  logic                  commit;
  logic [DATA_W-1:0]     operand;
  logic [DATA_W-1:0]     result;
  logic                  to_file;
  logic                  to_acc;
  logic                  touches_zero;
  logic [PC_W-1:0]       pc_next_seq;
  logic [BUS_DW-1:0]     pc_merged;

  logic                  file_we;
  logic [FADDR_W-1:0]    file_waddr;
  logic [DATA_W-1:0]     file_wdata;
  logic                  file_re;
  logic [FADDR_W-1:0]    file_raddr;
  logic [DATA_W-1:0]     file_rdata;

  // merges byte lanes of a bus write into an old word
  function automatic logic [BUS_DW-1:0] merge_be(
    input logic [BUS_DW-1:0] old_val,
    input logic [BUS_DW-1:0] new_val,
    input logic [3:0]        be
  );
    logic [BUS_DW-1:0] r;
    r = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // instruction-cycle enable
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tcy_cnt <= '0;
    end
    else if (tcy_tick)
    begin
      tcy_cnt <= '0;
    end
    else
    begin
      tcy_cnt <= tcy_cnt + TCW'(1);
    end
  end

  assign tcy_tick = (tcy_cnt == TCY_LAST);

  // bus decode and handshake
  assign busy      = (state != ST_IDLE);
  assign sel_file  = avs_address[FILE_SEL_BIT];
  assign bus_faddr = avs_address[FADDR_W+1:2];
  assign bus_wr    = avs_write && !busy;
  assign bus_rd_go = avs_read && (rd_stage == RD_ISSUE) && !(busy && sel_file);

  always_comb
  begin
    if (avs_write)
    begin
      avs_waitrequest = busy;
    end
    else if (avs_read)
    begin
      avs_waitrequest = (rd_stage != RD_DONE);
    end
    else
    begin
      avs_waitrequest = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_stage <= RD_ISSUE;
    end
    else if (!avs_read || rd_stage == RD_DONE)
    begin
      rd_stage <= RD_ISSUE;
    end
    else if (rd_stage == RD_CAPTURE || bus_rd_go)
    begin
      rd_stage <= rd_stage + 2'h1;
    end
  end

  assign stack_top = stack_mem[stack_ptr - SPW'(1)];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      avs_readdata <= '0;
    end
    else if (avs_read && rd_stage == RD_CAPTURE)
    begin
      avs_readdata <= '0;
      if (sel_file)
      begin
        avs_readdata[DATA_W-1:0] <= file_rdata;
      end
      else
      begin
        unique case (avs_address)
          ADDR_CMD:
          begin
            avs_readdata[CMD_OP_LSB +: 3]       <= cmd_op;
            avs_readdata[CMD_DEST]              <= cmd_dest;
            avs_readdata[CMD_ARG_LSB +: K_W]    <= cmd_arg;
          end
          ADDR_STATUS:
          begin
            avs_readdata[ST_BUSY]               <= busy;
            avs_readdata[ST_ZERO]               <= zero_flag;
            avs_readdata[ST_EXPIRED]            <= watchdog_expired_flag_n;
            avs_readdata[ST_SLEEP]              <= sleep_entered_flag_n;
          end
          ADDR_PC:     avs_readdata[PC_W-1:0]    <= program_counter;
          ADDR_LATCH:  avs_readdata[LATCH_W-1:0] <= upper_program_latch;
          ADDR_ACC:    avs_readdata[DATA_W-1:0]  <= acc;
          ADDR_STACK:
          begin
            avs_readdata[PC_W-1:0]              <= stack_top;
            avs_readdata[STK_PTR_LSB +: SPW]    <= stack_ptr;
          end
          default:     avs_readdata              <= '0;
        endcase
      end
    end
  end

  // command capture
  assign start = bus_wr && !sel_file && (avs_address == ADDR_CMD) && avs_byteenable[0];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_op   <= OP_NOP;
      cmd_dest <= 1'b0;
      cmd_arg  <= '0;
    end
    else if (start)
    begin
      cmd_op   <= cco_op_e'(avs_writedata[CMD_OP_LSB +: 3]);
      cmd_dest <= avs_writedata[CMD_DEST];
      cmd_arg  <= avs_writedata[CMD_ARG_LSB +: K_W];
    end
  end

  // sequencer: fetch the file operand, then wait out the instruction cycles
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= ST_IDLE;
      cyc_left <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          state    <= ST_RUN;
          cyc_left <= (cmd_op == OP_CALL) ? CYC_CALL : CYC_BASE;
        end
        ST_RUN:
        begin
          if (tcy_tick)
          begin
            if (cyc_left == CYC_BASE)
            begin
              state <= ST_IDLE;
            end
            cyc_left <= cyc_left - 2'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign commit = (state == ST_RUN) && tcy_tick && (cyc_left == CYC_BASE);

  // datapath
  assign operand     = file_rdata;
  assign pc_next_seq = program_counter + PC_W'(1);
  assign pc_merged   = merge_be(BUS_DW'(program_counter), avs_writedata, avs_byteenable);

  always_comb
  begin
    result       = ZERO_BYTE;
    to_file      = 1'b0;
    to_acc       = 1'b0;
    touches_zero = 1'b0;
    unique case (cmd_op)
      OP_CLEAR_REGISTER:
      begin
        to_file      = 1'b1;
        touches_zero = 1'b1;
      end
      OP_INVERT_REGISTER:
      begin
        result       = ~operand;
        to_file      = cmd_dest;
        to_acc       = !cmd_dest;
        touches_zero = 1'b1;
      end
      OP_CLEAR_ACCUMULATOR:
      begin
        to_acc       = 1'b1;
        touches_zero = 1'b1;
      end
      OP_DECREMENT_REGISTER:
      begin
        result       = operand - DATA_W'(1);
        to_file      = cmd_dest;
        to_acc       = !cmd_dest;
        touches_zero = 1'b1;
      end
      default:
      begin
        result = ZERO_BYTE;
      end
    endcase
  end

  // register file port sharing: executor while busy, bus otherwise
  assign file_we    = busy ? (commit && to_file) : (bus_wr && sel_file && avs_byteenable[0]);
  assign file_waddr = busy ? cmd_arg[FADDR_W-1:0] : bus_faddr;
  assign file_wdata = busy ? result : avs_writedata[DATA_W-1:0];
  assign file_re    = (state == ST_FETCH) || (bus_rd_go && sel_file);
  assign file_raddr = busy ? cmd_arg[FADDR_W-1:0] : bus_faddr;

  cco_regfile #(
    .DW    (DATA_W),
    .DEPTH (FILE_DEPTH),
    .AW    (FADDR_W)
  ) u_regfile (
    .mclk  (mclk),
    .arst_n(arst_n),
    .we    (file_we),
    .waddr (file_waddr),
    .wdata (file_wdata),
    .re    (file_re),
    .raddr (file_raddr),
    .rdata (file_rdata)
  );

  // program counter
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      program_counter <= PC_RST;
    end
    else if (commit)
    begin
      if (cmd_op == OP_CALL)
      begin
        program_counter <= {upper_program_latch[LATCH_W-1 -: PC_W-K_W], cmd_arg};
      end
      else
      begin
        program_counter <= pc_next_seq;
      end
    end
    else if (bus_wr && !sel_file && avs_address == ADDR_PC)
    begin
      program_counter <= pc_merged[PC_W-1:0];
    end
  end

  // return stack, circular
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stack_ptr <= '0;
    end
    else if (commit && cmd_op == OP_CALL)
    begin
      stack_ptr <= stack_ptr + SPW'(1);
    end
  end

  // entries cleared on reset so the top reads as zero before any call
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_mem[i] <= PC_RST;
      end
    end
    else if (commit && cmd_op == OP_CALL)
    begin
      stack_mem[stack_ptr] <= pc_next_seq;
    end
  end

  // upper program latch and accumulator
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      upper_program_latch <= LATCH_RST;
    end
    else if (bus_wr && !sel_file && avs_address == ADDR_LATCH && avs_byteenable[0])
    begin
      upper_program_latch <= avs_writedata[LATCH_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc <= ZERO_BYTE;
    end
    else if (commit && to_acc)
    begin
      acc <= result;
    end
    else if (bus_wr && !sel_file && avs_address == ADDR_ACC && avs_byteenable[0])
    begin
      acc <= avs_writedata[DATA_W-1:0];
    end
  end

  // zero flag; call and restart leave it alone
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_flag <= 1'b0;
    end
    else if (commit && touches_zero)
    begin
      zero_flag <= (result == ZERO_BYTE);
    end
  end

  // active-low status flags: restart sets them, core events clear them; set wins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      watchdog_expired_flag_n <= 1'b1;
      sleep_entered_flag_n    <= 1'b1;
    end
    else if (commit && cmd_op == OP_WATCHDOG_RESTART)
    begin
      watchdog_expired_flag_n <= 1'b1;
      sleep_entered_flag_n    <= 1'b1;
    end
    else
    begin
      if (watchdog_timeout)
      begin
        watchdog_expired_flag_n <= 1'b0;
      end
      if (sleep_entry)
      begin
        sleep_entered_flag_n <= 1'b0;
      end
    end
  end

  // watchdog clear strobes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      watchdog_count_clear     <= 1'b0;
      watchdog_prescaler_clear <= 1'b0;
    end
    else
    begin
      watchdog_count_clear     <= commit && (cmd_op == OP_WATCHDOG_RESTART);
      watchdog_prescaler_clear <= commit && (cmd_op == OP_WATCHDOG_RESTART);
    end
  end

endmodule // cco_exec

`default_nettype wire

// File: rtl/cco_regfile.sv
`default_nettype none

// data register file; read data come from a register one clock after re
module cco_regfile #(
  parameter int DW    = 8,
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          arst_n,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= '0;
    end
    else if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule // cco_regfile

`default_nettype wire

// File: test/cco_exec_properties.sv
`default_nettype none
module cco_exec_checker
  import cco_pkg::*;
#(
  parameter int TCY_DIV     = TCY_CLKS,
  parameter int STACK_DEPTH = 8,
  parameter int FILE_DEPTH  = 128
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              arst_n,
  // bus
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [BUS_DW-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [BUS_DW-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // core events and strobes
  input wire logic              watchdog_timeout,
  input wire logic              sleep_entry,
  input wire logic              watchdog_count_clear,
  input wire logic              watchdog_prescaler_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic acc_w = avs_write && !avs_waitrequest;
  wire logic cmd_acc = acc_w && avs_address == ADDR_CMD;
  wire logic rd_done = avs_read && !avs_waitrequest;
  logic [2:0]  last_op;
  logic [12:0] exp_pc;
  logic [4:0]  latch;
  logic [5:0]  since;
  logic        ev;
  logic        pcw;
  logic [2:0]  ncall;
  // settled: the last command has certainly committed
  wire logic settled = since > 6'(4 + 2 * TCY_DIV);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_op <= 3'h0;
      exp_pc  <= 13'h0000;
      latch   <= 5'h00;
      since   <= 6'h3F;
      ev      <= 1'b0;
      pcw     <= 1'b0;
      ncall   <= 3'h0;
    end
    else
    begin
      if (acc_w && avs_address == ADDR_LATCH && avs_byteenable[0])
        latch <= avs_writedata[4:0];
      pcw <= cmd_acc ? 1'b0 : (pcw || (acc_w && avs_address == ADDR_PC));
      ev  <= cmd_acc ? 1'b0 : (ev || watchdog_timeout || sleep_entry);
      since <= cmd_acc ? 6'h00 : (since == 6'h3F ? since : since + 6'h01);
      if (cmd_acc)
      begin
        last_op <= avs_writedata[2:0];
        exp_pc  <= {latch[4:3], avs_writedata[18:8]};
        if (avs_writedata[2:0] == OP_CALL)
          ncall <= ncall + 3'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  strobe_pair_a: assert property (watchdog_count_clear == watchdog_prescaler_clear)
    else $error("watchdog clear strobes differ");
  strobe_single_a: assert property ($rose(watchdog_count_clear) |=> !watchdog_count_clear)
    else $error("watchdog clear strobe too long");
  strobe_cause_a: assert property (watchdog_count_clear |-> last_op == OP_WATCHDOG_RESTART)
    else $error("watchdog clear without restart");
  restart_clears_a: assert property (cmd_acc && avs_writedata[2:0] == OP_WATCHDOG_RESTART
    |-> ##[1:12] watchdog_count_clear) else $error("restart gave no clear strobe");
  restart_flags_a: assert property (rd_done && avs_address == ADDR_STATUS && settled && !ev
    && last_op == OP_WATCHDOG_RESTART |-> avs_readdata[3:2] == 2'b11) else $error("flags not set");
  clear_zero_a: assert property (rd_done && avs_address == ADDR_STATUS && settled
    && (last_op == OP_CLEAR_REGISTER || last_op == OP_CLEAR_ACCUMULATOR) |-> avs_readdata[ST_ZERO])
    else $error("zero flag not set by clear");
  call_target_a: assert property (rd_done && avs_address == ADDR_PC && settled && !pcw
    && last_op == OP_CALL |-> avs_readdata[12:0] == exp_pc) else $error("call target wrong");
  stack_count_a: assert property (rd_done && avs_address == ADDR_STACK && settled
    |-> avs_readdata[18:16] == ncall) else $error("stack pointer wrong");
endmodule // cco_exec_checker

bind cco_exec cco_exec_checker #(.TCY_DIV(TCY_DIV), .STACK_DEPTH(STACK_DEPTH), .FILE_DEPTH(FILE_DEPTH)) i_chk (
  .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .watchdog_timeout(watchdog_timeout), .sleep_entry(sleep_entry),
  .watchdog_count_clear(watchdog_count_clear), .watchdog_prescaler_clear(watchdog_prescaler_clear));
`default_nettype wire

// File: test/tb_core_call_clear_decrement_ops.sv
`default_nettype none
module tb_core_call_clear_decrement_ops
  import cco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic [BUS_AW-1:0] avs_address = 10'h000;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [BUS_DW-1:0] avs_writedata = 32'h0000_0000;
  logic [BUS_DW-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              watchdog_timeout = 1'b0;
  logic              sleep_entry = 1'b0;
  logic              watchdog_count_clear;
  logic              watchdog_prescaler_clear;
  logic [31:0]       s;
  int                n_errors = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                strobes = 0;
  int                strobe_base = 0;

  always #4 mclk = ~mclk;

  cco_exec i_dut (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .watchdog_timeout(watchdog_timeout), .sleep_entry(sleep_entry),
    .watchdog_count_clear(watchdog_count_clear), .watchdog_prescaler_clear(watchdog_prescaler_clear));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (watchdog_count_clear === 1'b1)
      strobes++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bus_write(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task bus_read(input logic [9:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task rd_chk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    check(d, exp);
  endtask

  task zero_chk(input logic z);
    bus_read(ADDR_STATUS, s);
    check({31'h0, s[ST_ZERO]}, {31'h0, z});
  endtask

  function automatic logic [9:0] fa(input logic [6:0] f);
    return {1'b1, f, 2'b00};
  endfunction

  // issue one command and poll until the core is idle again
  task cmd(input logic [2:0] op, input logic dest, input logic [10:0] arg);
    bus_write(ADDR_CMD, {13'h0000, arg, 4'h0, dest, op});
    do bus_read(ADDR_STATUS, s); while (s[ST_BUSY] !== 1'b0);
  endtask

  task fop(input logic [2:0] op, input logic dest, input logic [6:0] f, input logic [7:0] init);
    logic [7:0] r;
    r = (op == OP_INVERT_REGISTER) ? ~init : init - 8'h01;
    bus_write(ADDR_ACC, 32'h0000_003C);
    bus_write(fa(f), {24'h0, init});
    cmd(op, dest, {4'h0, f});
    rd_chk(ADDR_ACC, {24'h0, dest ? 8'h3C : r});
    rd_chk(fa(f), {24'h0, dest ? r : init});
    zero_chk(r == 8'h00);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h0000_000C);
    rd_chk(ADDR_STACK, 32'h0000_0000);
    bus_write(10'h100, 32'hFFFF_FFFF);
    rd_chk(10'h100, 32'h0000_0000);
    cmd(OP_CLEAR_ACCUMULATOR, 1'h0, 11'h000);
    bus_write(ADDR_PC, 32'h0000_0123);
    bus_write(ADDR_LATCH, 32'h0000_0018);
    cmd(OP_CALL, 1'h0, 11'h7FF);
    rd_chk(ADDR_PC, 32'h0000_1FFF);
    rd_chk(ADDR_STACK, 32'h0001_0124);
    zero_chk(1'b1);
    bus_write(ADDR_LATCH, 32'h0000_0008);
    cmd(OP_CALL, 1'h0, 11'h000);
    rd_chk(ADDR_PC, 32'h0000_0800);
    rd_chk(ADDR_STACK, 32'h0002_0000);
    fop(OP_INVERT_REGISTER, 1'h0, 7'h0A, 8'hFF);
    fop(OP_INVERT_REGISTER, 1'h1, 7'h7F, 8'h0F);
    fop(OP_DECREMENT_REGISTER, 1'h0, 7'h00, 8'h01);
    fop(OP_DECREMENT_REGISTER, 1'h1, 7'h05, 8'h00);
    for (int f = 0; f < 128; f += 127)
    begin
      bus_write(fa(7'(f)), 32'h0000_00A5);
      cmd(OP_CLEAR_REGISTER, 1'h0, 11'(f));
      rd_chk(fa(7'(f)), 32'h0000_0000);
      zero_chk(1'b1);
    end
    fop(OP_INVERT_REGISTER, 1'h0, 7'h03, 8'h00);
    cmd(OP_CLEAR_ACCUMULATOR, 1'h0, 11'h000);
    rd_chk(ADDR_ACC, 32'h0000_0000);
    zero_chk(1'b1);
    @(posedge mclk);
    watchdog_timeout <= 1'b1;
    sleep_entry <= 1'b1;
    @(posedge mclk);
    watchdog_timeout <= 1'b0;
    sleep_entry <= 1'b0;
    bus_read(ADDR_STATUS, s);
    check({30'h0, s[3:2]}, 32'h0000_0000);
    strobe_base = strobes;
    cmd(OP_WATCHDOG_RESTART, 1'h0, 11'h000);
    check(32'(strobes - strobe_base), 32'h0000_0001);
    bus_read(ADDR_STATUS, s);
    check({30'h0, s[3:2]}, 32'h0000_0003);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    rd_chk(ADDR_PC, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // tb_core_call_clear_decrement_ops
`default_nettype wire
